// >>> cpu_speed_power_pkg.sv
// Constants for the core speed and power control block.
// Assumes an 8-bit special-function register space on the core side.
package cpu_speed_power_pkg;

    // ********************************************************************
    // Register addresses
    // ********************************************************************
    localparam logic [7:0] addr_power_control = 8'h87;
    localparam logic [7:0] addr_core_speed_control = 8'h9d;
    localparam logic [7:0] addr_speed_exit_mask = 8'h9e;
    localparam logic [7:0] addr_powerdown_exit_mask = 8'h9f;

    // ********************************************************************
    // Field positions and reset values
    // ********************************************************************
    localparam int speed_burst_pos = 3;
    localparam int pc_baud_double_pos = 7;
    localparam int pc_flag_high_pos = 3;
    localparam int pc_flag_low_pos = 2;
    localparam int pc_power_down_pos = 1;
    localparam int pc_idle_pos = 0;
    localparam logic [7:0] speed_reset = 8'h00;
    localparam logic [7:0] mask_reset = 8'h00;
    localparam logic [7:0] power_reset = 8'h00;
    localparam logic [7:0] speed_writable = 8'h0f;
    localparam logic [7:0] power_writable = 8'h8f;

    // ********************************************************************
    // Speed codes and divider counts
    // ********************************************************************
    localparam logic [2:0] speed_full = 3'h0;
    localparam logic [2:0] speed_div4 = 3'h1;
    localparam logic [2:0] speed_div16 = 3'h2;
    localparam logic [2:0] speed_div64 = 3'h3;
    localparam logic [2:0] speed_div256 = 3'h4;
    localparam logic [2:0] speed_div1024 = 3'h5;
    localparam logic [9:0] div_last_4 = 10'h003;
    localparam logic [9:0] div_last_16 = 10'h00f;
    localparam logic [9:0] div_last_64 = 10'h03f;
    localparam logic [9:0] div_last_256 = 10'h0ff;
    localparam logic [9:0] div_last_1024 = 10'h3ff;
    localparam logic [9:0] div_reset = 10'h000;

    typedef enum logic [1:0] {
        burst_run,
        burst_halt
    } burst_state_t;

endpackage

// >>> cpu_speed_power_control.sv
// Core clock speed, burst and power state control with its four registers.
// Assumes the core issues single-cycle register reads and writes on i_clock
// and that interrupt lines are already synchronous to i_clock, active low.
`timescale 1ns/1ps

module cpu_speed_power_control
    import cpu_speed_power_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    input wire logic [7:0] i_interrupt_lines_upper,
    input wire logic i_interrupt_line_zero,
    input wire logic i_enabled_interrupt_active,
    input wire logic i_instruction_done,
    input wire logic i_oscillator_config_sysclk_keep,
    output logic [7:0] o_reg_rdata,
    output logic o_core_clock_enable,
    output logic o_periph_clock_enable,
    output logic o_system_clock_enable,
    output logic o_memory_standby,
    output logic o_baud_double_bit,
    output logic o_power_down,
    output logic o_idle
);

    // ********************************************************************
    // State
    // ********************************************************************
    logic [7:0] core_speed_control;
    logic [7:0] speed_exit_mask;
    logic [7:0] powerdown_exit_mask;
    logic [7:0] power_control;
    logic [9:0] div_count;
    burst_state_t burst_state;
    logic [7:0] next_core_speed_control;
    logic [7:0] next_speed_exit_mask;
    logic [7:0] next_powerdown_exit_mask;
    logic [7:0] next_power_control;
    logic [9:0] next_div_count;
    burst_state_t next_burst_state;
    logic [7:0] next_reg_rdata;
    logic [7:0] line_active;
    logic speed_exit;
    logic pd_exit;
    logic [9:0] div_last;
    logic div_tick;
    logic burst_on;
    logic slowed;
    logic pd_on;
    logic idle_on;

    // ********************************************************************
    // Interrupt exits
    // ********************************************************************
    // Bit 0 of each mask watches line zero; bits 7 to 1 watch lines 7 to 1.
    // The interrupt enable registers are deliberately not consulted here.
    assign line_active = ~{i_interrupt_lines_upper[6:0], i_interrupt_line_zero};
    assign speed_exit = |(line_active & speed_exit_mask);
    assign pd_exit = |(line_active & powerdown_exit_mask);

    // ********************************************************************
    // Divider
    // ********************************************************************
    always_comb begin
        case (core_speed_control[2:0])
            speed_div4: div_last = div_last_4;
            speed_div16: div_last = div_last_16;
            speed_div64: div_last = div_last_64;
            speed_div256: div_last = div_last_256;
            speed_div1024: div_last = div_last_1024;
            default: div_last = div_reset;
        endcase
    end

    // Reserved codes fall to full speed rather than an undefined ratio.
    assign slowed = (div_last != div_reset);
    assign burst_on = core_speed_control[speed_burst_pos] && slowed;
    assign div_tick = (div_count == div_last);
    assign pd_on = power_control[pc_power_down_pos];
    assign idle_on = power_control[pc_idle_pos] && !pd_on;

    // ********************************************************************
    // Next-state logic
    // ********************************************************************
    always_comb begin
        next_core_speed_control = core_speed_control;
        next_speed_exit_mask = speed_exit_mask;
        next_powerdown_exit_mask = powerdown_exit_mask;
        next_power_control = power_control;
        next_div_count = div_count;
        next_burst_state = burst_state;
        next_reg_rdata = 8'h00;

        if (i_reg_write) begin
            if (i_reg_addr == addr_core_speed_control) begin
                next_core_speed_control = i_reg_wdata & speed_writable;
            end else if (i_reg_addr == addr_speed_exit_mask) begin
                next_speed_exit_mask = i_reg_wdata;
            end else if (i_reg_addr == addr_powerdown_exit_mask) begin
                next_powerdown_exit_mask = i_reg_wdata;
            end else if (i_reg_addr == addr_power_control) begin
                next_power_control = i_reg_wdata & power_writable;
            end
        end

        // Exits are applied after the write so a coincident write cannot mask them.
        if (speed_exit) begin
            next_core_speed_control = speed_reset;
        end
        if (pd_exit) begin
            next_power_control[pc_power_down_pos] = 1'b0;
        end
        if (i_enabled_interrupt_active) begin
            next_power_control[pc_idle_pos] = 1'b0;
        end

        if (i_reg_read) begin
            if (i_reg_addr == addr_core_speed_control) begin
                next_reg_rdata = core_speed_control & speed_writable;
            end else if (i_reg_addr == addr_speed_exit_mask) begin
                next_reg_rdata = speed_exit_mask;
            end else if (i_reg_addr == addr_powerdown_exit_mask) begin
                next_reg_rdata = powerdown_exit_mask;
            end else if (i_reg_addr == addr_power_control) begin
                next_reg_rdata = power_control & power_writable;
            end
        end

        // Burst keeps the same counter as plain division, so a full
        // instruction is followed by a halt of one whole divider period.
        case (burst_state)
            burst_run: begin
                next_div_count = div_reset;
                if (burst_on && i_instruction_done) begin
                    next_burst_state = burst_halt;
                end
            end
            burst_halt: begin
                next_div_count = div_count + 10'h001;
                if (!burst_on || div_tick) begin
                    next_burst_state = burst_run;
                    next_div_count = div_reset;
                end
            end
            default: begin
                next_burst_state = burst_run;
            end
        endcase
        if (!burst_on && slowed) begin
            next_div_count = div_tick ? div_reset : div_count + 10'h001;
        end else if (!slowed) begin
            next_div_count = div_reset;
        end
    end

    // ********************************************************************
    // Registers
    // ********************************************************************
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            core_speed_control <= speed_reset;
            speed_exit_mask <= mask_reset;
            powerdown_exit_mask <= mask_reset;
            power_control <= power_reset;
            div_count <= div_reset;
            burst_state <= burst_run;
            o_reg_rdata <= 8'h00;
        end else begin
            core_speed_control <= next_core_speed_control;
            speed_exit_mask <= next_speed_exit_mask;
            powerdown_exit_mask <= next_powerdown_exit_mask;
            power_control <= next_power_control;
            div_count <= next_div_count;
            burst_state <= next_burst_state;
            o_reg_rdata <= next_reg_rdata;
        end
    end

    // ********************************************************************
    // Clock enables
    // ********************************************************************
    always_comb begin
        if (pd_on) begin
            o_core_clock_enable = 1'b0;
        end else if (idle_on) begin
            o_core_clock_enable = 1'b0;
        end else if (burst_on) begin
            o_core_clock_enable = (burst_state == burst_run);
        end else if (slowed) begin
            o_core_clock_enable = div_tick;
        end else begin
            o_core_clock_enable = 1'b1;
        end
    end

    // The system clock never sees the divider; only power-down can stop it.
    assign o_periph_clock_enable = !pd_on;
    assign o_system_clock_enable = !pd_on || i_oscillator_config_sysclk_keep;
    assign o_memory_standby = burst_on && (burst_state == burst_halt);
    assign o_baud_double_bit = power_control[pc_baud_double_pos];
    assign o_power_down = pd_on;
    assign o_idle = idle_on;

endmodule

// >>> cpu_speed_power_properties.sv
// Checker for the speed and power control ports.
// Assumes it is bound to the block's top module.
`timescale 1ns/1ps
module cpu_speed_power_properties
    import cpu_speed_power_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    input wire logic [7:0] i_interrupt_lines_upper,
    input wire logic i_interrupt_line_zero,
    input wire logic i_enabled_interrupt_active,
    input wire logic i_instruction_done,
    input wire logic i_oscillator_config_sysclk_keep,
    input wire logic [7:0] o_reg_rdata,
    input wire logic o_core_clock_enable,
    input wire logic o_periph_clock_enable,
    input wire logic o_system_clock_enable,
    input wire logic o_memory_standby,
    input wire logic o_baud_double_bit,
    input wire logic o_power_down,
    input wire logic o_idle
);
    logic [7:0] spx, pdx, next_spx, next_pdx, low;
    // The masks are shadowed from writes, as no internal state is visible.
    assign low = {~i_interrupt_lines_upper[6:0], ~i_interrupt_line_zero};
    always_comb begin
        next_spx = (i_reg_write && i_reg_addr == addr_speed_exit_mask) ?
            i_reg_wdata : spx;
        next_pdx = (i_reg_write && i_reg_addr == addr_powerdown_exit_mask) ?
            i_reg_wdata : pdx;
    end
    always_ff @(posedge i_clock) begin
        spx <= i_rst ? mask_reset : next_spx;
        pdx <= i_rst ? mask_reset : next_pdx;
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    speed_exit_a: assert property (|(low & spx)
        |=> o_core_clock_enable || o_power_down || o_idle)
        else $error("speed exit left core slow");
    pd_exit_a: assert property (|(low & pdx) |=> !o_power_down)
        else $error("power down not left");
    pd_halts_a: assert property (o_power_down
        |-> !o_core_clock_enable && !o_periph_clock_enable)
        else $error("clocks run in power down");
    pd_wins_a: assert property (o_power_down |-> !o_idle)
        else $error("idle shown in power down");
    idle_exit_a: assert property (i_enabled_interrupt_active |=> !o_idle)
        else $error("idle kept after interrupt");
    sys_gate_a: assert property (
        o_system_clock_enable != (o_power_down && !i_oscillator_config_sysclk_keep))
        else $error("system clock gate wrong");
    standby_halt_a: assert property (o_memory_standby |-> !o_core_clock_enable)
        else $error("core clocked in standby");
    baud_bit_a: assert property (i_reg_write && i_reg_addr == addr_power_control
        |=> o_baud_double_bit == $past(i_reg_wdata[7]))
        else $error("baud bit not written");
    speed_upper_a: assert property (i_reg_read && i_reg_addr == addr_core_speed_control
        |=> o_reg_rdata[7:4] == 4'h0)
        else $error("speed upper bits nonzero");
    cover property (o_memory_standby);
    cover property (|(low & pdx) && o_power_down);
    cover property (o_idle ##1 !o_idle);
endmodule
bind cpu_speed_power_control cpu_speed_power_properties cpu_speed_power_properties_i (.*);

// >>> core_model.sv
// Core model: one instruction ends after each enabled core clock.
// Assumes its clock and enable come from the block under test.
`timescale 1ns/1ps
module core_model (
    input wire logic i_clock,
    input wire logic i_core_clock_enable,
    output logic o_instruction_done
);
    logic done_q = 1'b0;
    assign o_instruction_done = done_q;
    always @(posedge i_clock) begin
        done_q <= i_core_clock_enable;
    end
endmodule

// >>> tb.sv
// Self-checking bench for the speed and power control block.
// Assumes the block and the core model share one 10 MHz clock.
`timescale 1ns/1ps
module tb;
    import cpu_speed_power_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, upper = 8'hff, rdata, lfsr = 8'h5b;
    logic wr = 1'b0, rd = 1'b0, line0 = 1'b1, en_act = 1'b0, keep = 1'b0;
    logic done, core_en, periph_en, sys_en, standby, baud, pd, idle;
    logic [7:0] regs [5] = '{8'h87, 8'h9d, 8'h9e, 8'h9f, 8'h40};
    int failures = 0, n_compared = 0, cnt;
    cpu_speed_power_control cpu_speed_power_control_i (.i_clock(i_clock), .i_rst(i_rst),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_write(wr), .i_reg_read(rd),
        .i_interrupt_lines_upper(upper), .i_interrupt_line_zero(line0),
        .i_enabled_interrupt_active(en_act), .i_instruction_done(done),
        .i_oscillator_config_sysclk_keep(keep), .o_reg_rdata(rdata),
        .o_core_clock_enable(core_en), .o_periph_clock_enable(periph_en),
        .o_system_clock_enable(sys_en), .o_memory_standby(standby),
        .o_baud_double_bit(baud), .o_power_down(pd), .o_idle(idle));
    core_model core_model_i (.i_clock(i_clock), .i_core_clock_enable(core_en),
        .o_instruction_done(done));
    function automatic logic [7:0] step(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic int div_of(input int c);
        return (c == 0) ? 1 : 1 << (2 * c);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clock);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clock);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic drop(input int n, input logic lvl);
        @(posedge i_clock);
        if (n == 0) begin
            line0 <= lvl;
        end else begin
            upper[n - 1] <= lvl;
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        forever #50 i_clock = ~i_clock;
    end
    initial begin
        repeat (20000) @(posedge i_clock);
        failures++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] v;
        logic [7:0] w;
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        #1 check({core_en, periph_en, sys_en, standby, baud, pd, idle}, 16'h0070);
        for (int i = 0; i < 5; i++) begin
            rreg(regs[i], v);
            check(v, 8'h00);
        end
        for (int i = 0; i < 8; i++) begin
            lfsr = step(lfsr);
            wreg(addr_speed_exit_mask, lfsr);
            rreg(addr_speed_exit_mask, v);
            check(v, lfsr);
            // Reserved speed codes are never written by software.
            w = {lfsr[7:3], lfsr[2:0] % 3'h6};
            wreg(addr_core_speed_control, w);
            rreg(addr_core_speed_control, v);
            check(v, w & 8'h0f);
            wreg(addr_power_control, lfsr & 8'hfc);
            rreg(addr_power_control, v);
            check(v, lfsr & 8'h8c);
            check(baud, lfsr[7]);
        end
        wreg(addr_core_speed_control, 8'h00);
        for (int c = 0; c < 6; c++) begin
            wreg(addr_core_speed_control, 8'(c));
            cnt = 0;
            repeat (4 * div_of(c)) begin
                @(posedge i_clock);
                #1 cnt += int'(core_en);
            end
            check(16'(cnt), 16'h0004);
        end
        wreg(addr_core_speed_control, 8'h09);
        cnt = 0;
        repeat (60) begin
            @(posedge i_clock);
            #1 cnt += int'(standby);
        end
        check(cnt != 0, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wreg(addr_speed_exit_mask, 8'h01 << i);
            wreg(addr_core_speed_control, 8'h0d);
            drop((i + 1) % 8, 1'b0);
            rreg(addr_core_speed_control, v);
            check(v, 8'h0d);
            drop((i + 1) % 8, 1'b1);
            drop(i, 1'b0);
            rreg(addr_core_speed_control, v);
            check(v, 8'h00);
            drop(i, 1'b1);
        end
        wreg(addr_powerdown_exit_mask, 8'h80);
        wreg(addr_power_control, 8'h03);
        #1 check({pd, idle, periph_en, sys_en}, 16'h0008);
        @(posedge i_clock);
        // Software keeps the system clock running for a fast exit.
        keep <= 1'b1;
        @(posedge i_clock);
        #1 check(sys_en, 1'b1);
        drop(7, 1'b0);
        @(posedge i_clock);
        #1 check({pd, idle}, 16'h0001);
        drop(7, 1'b1);
        @(posedge i_clock);
        en_act <= 1'b1;
        @(posedge i_clock);
        #1 check(idle, 1'b0);
        en_act <= 1'b0;
        tally_and_finish();
    end
endmodule
